// ==== inc/dss_defines.svh ====
`ifndef DSS_DEFINES_SVH
`define DSS_DEFINES_SVH

// register byte offsets
`define DSS_CTRL_OFS      8'h00
`define DSS_TIMEBASE_OFS  8'h04
`define DSS_PRESET_OFS    8'h08
`define DSS_STATUS_OFS    8'h0C
`define DSS_COUNT_OFS     8'h10
`define DSS_TIMER_OFS     8'h14
`define DSS_PSTEP_OFS     8'h18
`define DSS_CSTEP_OFS     8'h1C
`define DSS_OUT_OFS       8'h20
`define DSS_STEPCFG_BASE  2'h1
`define DSS_PATTERN_BASE  2'h2

// control register fields
`define DSS_CTRL_RUN      0
`define DSS_CTRL_JOG      1
`define DSS_CTRL_RESET    2
`define DSS_CTRL_MODE     3
`define DSS_CTRL_RETAIN   4
`define DSS_CTRL_EVTVAR   5
`define DSS_CTRL_W        6
`define DSS_CTRL_RST_VAL  6'h30

// status register fields
`define DSS_STAT_FLAG     0
`define DSS_STAT_DONE     1

// step configuration fields
`define DSS_CFG_CNT_MSB   15
`define DSS_CFG_EVT_LSB   16
`define DSS_CFG_EVT_MSB   19
`define DSS_CFG_EVT_EN    20

// reset values and step range limits
`define DSS_PRESET_RST    5'h01
`define DSS_TIMEBASE_RST  16'h0001
`define DSS_STEP_FIRST    5'h01
`define DSS_STEP_LAST     5'h10

// bus responses
`define DSS_RESP_OKAY     2'h0
`define DSS_RESP_SLVERR   2'h2

// timing: clock period, hundredth of a second, scan period
`define DSS_CLK_NS        100
`define DSS_HUND_NS       10000000
`define DSS_SCAN_NS       1000000

`endif

// ==== inc/dss_pkg.sv ====
package dss_pkg;
	typedef enum logic [1:0] {DSS_OFF, DSS_STEP, DSS_DONE} dss_state_t;
	typedef logic [4:0]  dss_step_t;
	typedef logic [15:0] dss_word_t;
endpackage

// ==== rtl/dss_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dss_defines.svh"

module dss_sequencer
	import dss_pkg::*;
#(
	parameter int unsigned HUND_CYCLES = `DSS_HUND_NS / `DSS_CLK_NS,
	parameter int unsigned SCAN_CYCLES = `DSS_SCAN_NS / `DSS_CLK_NS
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address and data
	input  wire logic        awvalid,
	output var  logic        awready,
	input  wire logic [7:0]  awaddr,
	input  wire logic        wvalid,
	output var  logic        wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	// axi4-lite write response
	output var  logic        bvalid,
	input  wire logic        bready,
	output var  logic [1:0]  bresp,
	// axi4-lite read
	input  wire logic        arvalid,
	output var  logic        arready,
	input  wire logic [7:0]  araddr,
	output var  logic        rvalid,
	input  wire logic        rready,
	output var  logic [31:0] rdata,
	output var  logic [1:0]  rresp,
	// drum events and outputs
	input  wire logic [15:0] event_in,
	output var  logic [15:0] drum_out,
	output var  logic        completion_flag
);

	// elaboration check: each scan may use one hundredth at most,
	// so a hundredth shorter than a scan would lose time
	if (HUND_CYCLES < 1 || SCAN_CYCLES < 1
			|| HUND_CYCLES < SCAN_CYCLES) begin : g_bad_tick
		$error("tick periods unusable for the sequencer");
	end

	// configuration and status state
	dss_state_t      state;
	logic [5:0]      ctrl;
	dss_word_t       timebase;
	dss_step_t       preset_step_value;
	dss_step_t       current_step_value;
	dss_word_t       step_count_value;
	dss_word_t       step_timer_value;
	logic [20:0]     step_cfg [16];
	dss_word_t       pattern [16];
	logic            jog_prev;
	logic            hund_pend;
	logic [31:0]     hund_cnt;
	logic [31:0]     scan_cnt;
	logic            scan_tick;
	logic            hund_tick;

	// bus holding state
	logic            aw_full;
	logic            w_full;
	logic [7:0]      aw_addr;
	logic [31:0]     w_data;
	logic [3:0]      w_strb;

	// tick dividers: the scan tick paces all sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scan_cnt  <= 32'h0;
			hund_cnt  <= 32'h0;
			scan_tick <= 1'b0;
			hund_tick <= 1'b0;
		end else begin
			scan_tick <= (scan_cnt == SCAN_CYCLES - 1);
			hund_tick <= (hund_cnt == HUND_CYCLES - 1);
			scan_cnt  <= (scan_cnt == SCAN_CYCLES - 1) ? 32'h0
				: scan_cnt + 32'h1;
			hund_cnt  <= (hund_cnt == HUND_CYCLES - 1) ? 32'h0
				: hund_cnt + 32'h1;
		end
	end

	// control fields
	wire run_in     = ctrl[`DSS_CTRL_RUN];
	wire jog_in     = ctrl[`DSS_CTRL_JOG];
	wire reset_in   = ctrl[`DSS_CTRL_RESET];
	wire run_mode   = ctrl[`DSS_CTRL_MODE];
	wire retentive  = ctrl[`DSS_CTRL_RETAIN];
	wire evt_var    = ctrl[`DSS_CTRL_EVTVAR];

	// last used step: highest step with count or event programmed
	dss_step_t last_used;
	always_comb begin
		last_used = `DSS_STEP_FIRST;
		for (int i = 0; i < 16; i++) begin
			if (step_cfg[i][`DSS_CFG_CNT_MSB:0] != 16'h0
					|| step_cfg[i][`DSS_CFG_EVT_EN])
				last_used = 5'(i + 1);
		end
	end

	// current step decode
	wire [3:0]  cur_idx  = 4'(current_step_value - `DSS_STEP_FIRST);
	wire [20:0] cur_cfg  = step_cfg[cur_idx];
	wire [3:0]  evt_sel  = cur_cfg[`DSS_CFG_EVT_MSB:`DSS_CFG_EVT_LSB];
	wire        evt_used = evt_var & cur_cfg[`DSS_CFG_EVT_EN];
	// unused event counts as true; event gates the timer
	wire        evt_ok   = !evt_used || event_in[evt_sel];
	wire        at_last  = (current_step_value >= last_used);
	// jog edge against the level of the previous tick
	wire        jog_edge = evt_var & jog_in & !jog_prev;
	wire        tb_hit   = (step_timer_value + 16'h1 >= timebase);
	wire        step_end = evt_ok
		&& step_count_value >= cur_cfg[`DSS_CFG_CNT_MSB:0];
	wire        go_preset = !retentive || completion_flag;

	// hundredth ticks wait for the next scan; set beats consume
	always_ff @(posedge aclk) begin
		if (!aresetn)
			hund_pend <= 1'b0;
		else
			hund_pend <= hund_tick | (hund_pend & !scan_tick);
	end

	// once per scan: state machine moves on scan ticks only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state              <= DSS_OFF;
			current_step_value <= `DSS_PRESET_RST;
			step_count_value   <= 16'h0;
			step_timer_value   <= 16'h0;
			completion_flag    <= 1'b0;
			jog_prev           <= 1'b0;
		end else if (scan_tick) begin
			jog_prev <= jog_in;
			case (state)
			DSS_OFF: begin
				if (run_mode) begin
					state           <= DSS_STEP;
					completion_flag <= 1'b0;
					if (go_preset) begin
						current_step_value <= preset_step_value;
						step_count_value   <= 16'h0;
						step_timer_value   <= 16'h0;
					end
				end
			end
			DSS_STEP, DSS_DONE: begin
				if (!run_mode) begin
					state <= DSS_OFF;
				end else if (reset_in) begin
					state              <= DSS_STEP;
					current_step_value <= preset_step_value;
					step_count_value   <= 16'h0;
					step_timer_value   <= 16'h0;
					completion_flag    <= 1'b0;
				end else if (state == DSS_DONE) begin
					state <= DSS_DONE;
				end else if (jog_edge || (run_in && step_end)) begin
					step_count_value <= 16'h0;
					step_timer_value <= 16'h0;
					if (at_last) begin
						state           <= DSS_DONE;
						completion_flag <= 1'b1;
					end else begin
						current_step_value <= current_step_value
							+ 5'h1;
					end
				end else if (run_in && evt_ok && hund_pend) begin
					if (tb_hit) begin
						step_timer_value <= 16'h0;
						step_count_value <= step_count_value + 16'h1;
					end else begin
						step_timer_value <= step_timer_value + 16'h1;
					end
				end
			end
			default: state <= DSS_OFF;
			endcase
		end
	end

	// outputs follow the current pattern in run mode only
	always_ff @(posedge aclk) begin
		if (!aresetn)
			drum_out <= 16'h0;
		else
			drum_out <= (state != DSS_OFF) ? pattern[cur_idx] : 16'h0;
	end

	// write channel: address and data are latched in either order
	wire wr_go   = aw_full & w_full & !bvalid;
	wire aw_take = awvalid & awready;
	wire w_take  = wvalid & wready;
	wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}},
		{8{w_strb[1]}}, {8{w_strb[0]}}};

	// write address decode
	wire sel_ctrl  = (aw_addr == `DSS_CTRL_OFS);
	wire sel_tb    = (aw_addr == `DSS_TIMEBASE_OFS);
	wire sel_pre   = (aw_addr == `DSS_PRESET_OFS);
	wire sel_cfg   = (aw_addr[7:6] == `DSS_STEPCFG_BASE);
	wire sel_pat   = (aw_addr[7:6] == `DSS_PATTERN_BASE);
	wire [3:0] wix = aw_addr[5:2];
	wire wr_ok     = sel_ctrl | sel_tb | sel_pre | sel_cfg | sel_pat;
	wire [31:0] cfg_old = {11'h0, step_cfg[wix]};
	wire [31:0] pat_old = {16'h0, pattern[wix]};
	wire [31:0] cfg_new = (cfg_old & ~wmask) | (w_data & wmask);
	wire [31:0] pat_new = (pat_old & ~wmask) | (w_data & wmask);
	wire [31:0] ctl_new = ({26'h0, ctrl} & ~wmask) | (w_data & wmask);
	wire [31:0] tb_new  = ({16'h0, timebase} & ~wmask) | (w_data & wmask);
	wire [31:0] pre_new = ({27'h0, preset_step_value} & ~wmask)
		| (w_data & wmask);
	wire pre_valid = pre_new[4:0] >= `DSS_STEP_FIRST
		&& pre_new[4:0] <= `DSS_STEP_LAST;

	// write handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= `DSS_RESP_OKAY;
			aw_addr <= 8'h0;
			w_data  <= 32'h0;
			w_strb  <= 4'h0;
		end else begin
			if (aw_take) begin
				aw_full <= 1'b1;
				awready <= 1'b0;
				aw_addr <= awaddr;
			end
			if (w_take) begin
				w_full <= 1'b1;
				wready <= 1'b0;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (wr_go) begin
				bvalid <= 1'b1;
				bresp  <= wr_ok ? `DSS_RESP_OKAY : `DSS_RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				aw_full <= 1'b0;
				w_full  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// register writes; retention bit resets to retentive
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl              <= `DSS_CTRL_RST_VAL;
			timebase          <= `DSS_TIMEBASE_RST;
			preset_step_value <= `DSS_PRESET_RST;
		end else if (wr_go) begin
			if (sel_ctrl)
				ctrl <= ctl_new[`DSS_CTRL_W-1:0];
			if (sel_tb)
				timebase <= tb_new[15:0];
			// only configuration writes move the preset
			if (sel_pre && pre_valid)
				preset_step_value <= pre_new[4:0];
		end
	end

	// per-step tables; no reset so they can map to memory
	always_ff @(posedge aclk) begin
		if (wr_go && sel_cfg)
			step_cfg[wix] <= cfg_new[20:0];
		if (wr_go && sel_pat)
			pattern[wix] <= pat_new[15:0];
	end

	// read decode, the four counters sit at consecutive words
	logic [31:0] rd_val;
	logic        rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		if (araddr == `DSS_CTRL_OFS)
			rd_val = {26'h0, ctrl};
		else if (araddr == `DSS_TIMEBASE_OFS)
			rd_val = {16'h0, timebase};
		else if (araddr == `DSS_PRESET_OFS)
			rd_val = {27'h0, preset_step_value};
		else if (araddr == `DSS_STATUS_OFS)
			rd_val = {30'h0, state == DSS_DONE, completion_flag};
		else if (araddr == `DSS_COUNT_OFS)
			rd_val = {16'h0, step_count_value};
		else if (araddr == `DSS_TIMER_OFS)
			rd_val = {16'h0, step_timer_value};
		else if (araddr == `DSS_PSTEP_OFS)
			rd_val = {27'h0, preset_step_value};
		else if (araddr == `DSS_CSTEP_OFS)
			rd_val = {27'h0, current_step_value};
		else if (araddr == `DSS_OUT_OFS)
			rd_val = {16'h0, drum_out};
		else if (araddr[7:6] == `DSS_STEPCFG_BASE)
			rd_val = {11'h0, step_cfg[araddr[5:2]]};
		else if (araddr[7:6] == `DSS_PATTERN_BASE)
			rd_val = {16'h0, pattern[araddr[5:2]]};
		else begin
			rd_val = 32'h0;
			rd_ok  = 1'b0;
		end
	end

	// read handshake: data captured with the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= `DSS_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_val;
			rresp   <= rd_ok ? `DSS_RESP_OKAY : `DSS_RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	wire active = scan_tick && state != DSS_OFF && run_mode;

	sequence s_reset_tick;
		active && reset_in;
	endsequence
	sequence s_at_preset;
		current_step_value == preset_step_value
			&& step_count_value == 16'h0 && step_timer_value == 16'h0;
	endsequence

	property p_reset_preset;
		s_reset_tick |=> s_at_preset;
	endproperty
	a_reset_preset: assert property (p_reset_preset)
		else $error("reset did not hold preset step");

	property p_freeze;
		active && !reset_in && !run_in && !jog_edge |=>
			$stable(current_step_value) && $stable(step_count_value)
			&& $stable(step_timer_value);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("sequencer moved with run low");

	property p_done_holds;
		active && state == DSS_DONE && !reset_in |=>
			state == DSS_DONE && completion_flag;
	endproperty
	a_done_holds: assert property (p_done_holds)
		else $error("completed state left without reset");

	property p_done_last;
		state == DSS_DONE |-> current_step_value == last_used
			|| $changed(step_cfg[0]) || $past(wr_go);
	endproperty
	a_done_last: assert property (p_done_last)
		else $error("completed step is not the last used step");

	property p_entry_clears;
		scan_tick && state == DSS_OFF && run_mode |=>
			!completion_flag && state == DSS_STEP;
	endproperty
	a_entry_clears: assert property (p_entry_clears)
		else $error("run entry did not clear completion");

	property p_nonret_entry;
		scan_tick && state == DSS_OFF && run_mode && !retentive
			|=> s_at_preset;
	endproperty
	a_nonret_entry: assert property (p_nonret_entry)
		else $error("non-retentive entry did not initialise");

	property p_ret_entry;
		scan_tick && state == DSS_OFF && run_mode && retentive
			&& !completion_flag |=> $stable(current_step_value)
			&& $stable(step_count_value);
	endproperty
	a_ret_entry: assert property (p_ret_entry)
		else $error("retentive entry changed counters");

	property p_preset_cfg;
		$changed(preset_step_value) |-> $past(wr_go) && $past(sel_pre);
	endproperty
	a_preset_cfg: assert property (p_preset_cfg)
		else $error("preset changed without a write");

	property p_out_off;
		state == DSS_OFF |=> drum_out == 16'h0;
	endproperty
	a_out_off: assert property (p_out_off)
		else $error("outputs driven outside run mode");

	property p_jog_clear;
		active && !reset_in && state == DSS_STEP && jog_edge
			&& !at_last |=> step_timer_value == 16'h0
			&& current_step_value == $past(current_step_value) + 5'h1;
	endproperty
	a_jog_clear: assert property (p_jog_clear)
		else $error("jog did not advance and clear timer");

	property p_timer_range;
		step_timer_value <= timebase || $changed(timebase);
	endproperty
	a_timer_range: assert property (p_timer_range)
		else $error("timer passed the timebase");

endmodule
`default_nettype wire

// ==== dv/dss_event_src.sv ====
`timescale 1ns/1ps
`default_nettype none
module dss_event_src (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// requested levels and driven event lines
	input  wire logic [15:0] want,
	output var  logic [15:0] event_in
);
	// events change just after an edge, like contacts updated by ladder logic
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			event_in <= 16'h0000;
		end else begin
			event_in <= want;
		end
	end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dss_defines.svh"
module tb_top;
	// short counts keep the run brief; hundredth period not below scan period
	localparam int SCAN = 2;
	localparam int HUND = 4;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, completion_flag;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, ctl, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic [15:0] want, event_in, drum_out;
	int          n_mismatch, check_count;

	dss_sequencer #(.HUND_CYCLES(HUND), .SCAN_CYCLES(SCAN)) dut (
		.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready,
		.wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
		.araddr, .rvalid, .rready, .rdata, .rresp, .event_in, .drum_out,
		.completion_flag
	);
	dss_event_src u_evt (.aclk(aclk), .aresetn(aresetn), .want(want),
		.event_in(event_in));

	// free-running bus clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] er = `DSS_RESP_OKAY);
		logic pa, pw, ta, tw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pa || pw) begin
			@(negedge aclk);
			ta = pa && awready === 1'b1;
			tw = pw && wready === 1'b1;
			@(posedge aclk);
			if (ta) begin
				awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (tw) begin
				wvalid <= 1'b0;
				pw = 1'b0;
			end
		end
		do @(negedge aclk); while (bvalid !== 1'b1);
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		@(posedge aclk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] rr);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		v = rdata;
		rr = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		rd(a, d, r);
		chk(nm, e, d);
		chk("rresp", 32'h0, {30'h0, r});
	endtask

	task automatic scans(input int n);
		repeat (n * SCAN) @(posedge aclk);
	endtask

	// control written, then two scans so the sequencer has seen it
	task automatic setc(input logic [31:0] v);
		ctl = v;
		wr(`DSS_CTRL_OFS, ctl);
		scans(2);
	endtask

	// each jog level is held past a scan tick so the edge is seen
	task automatic jog;
		wr(`DSS_CTRL_OFS, ctl | 32'h2);
		scans(2);
		wr(`DSS_CTRL_OFS, ctl);
		scans(2);
	endtask

	task automatic wait_done;
		d = 32'h0;
		for (int i = 0; i < 100 && d !== 32'h3; i++) begin
			rd(`DSS_STATUS_OFS, d, r);
		end
		chk("status", 32'h3, d);
	endtask

	function automatic logic [15:0] pat(input int i);
		return 16'hA500 | 16'(i);
	endfunction

	task automatic wrap_up;
		$display("Mismatches %0d of %0d checks", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		repeat (60000) @(posedge aclk);
		n_mismatch++;
		wrap_up();
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, want} = 64'h0;
		wstrb = 4'hF;
		ctl = 32'h30;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rc(`DSS_CTRL_OFS, 32'h30, "ctrl");
		rc(`DSS_PSTEP_OFS, 32'h1, "preset");
		rc(`DSS_CSTEP_OFS, 32'h1, "step");
		rc(`DSS_COUNT_OFS, 32'h0, "count");
		rc(`DSS_TIMER_OFS, 32'h0, "timer");
		rc(`DSS_STATUS_OFS, 32'h0, "status");
		rd(8'h3C, d, r);
		chk("unmapped", {30'h0, `DSS_RESP_SLVERR}, {30'h0, r});
		wr(8'h3C, 32'h0, `DSS_RESP_SLVERR);
		// timed step 1, event step 2 on line 5, short last step 3
		for (int i = 0; i < 16; i++) begin
			wr(8'h40 + 8'(4 * i), (i == 0) ? 32'h2 : (i == 1) ?
				32'h00150000 : (i == 2) ? 32'h1 : 32'h0);
			wr(8'h80 + 8'(4 * i), {16'h0000, pat(i)});
		end
		// pins are compared mid-cycle, away from the edge that moves them
		@(negedge aclk);
		chk("idle out", 32'h0, {16'h0, drum_out});
		setc(32'h38);
		@(negedge aclk);
		chk("entry out", {16'h0, pat(0)}, {16'h0, drum_out});
		jog();
		rc(`DSS_CSTEP_OFS, 32'h2, "jog step");
		rc(`DSS_TIMER_OFS, 32'h0, "jog timer");
		scans(10);
		rc(`DSS_CSTEP_OFS, 32'h2, "frozen step");
		@(negedge aclk);
		chk("frozen out", {16'h0, pat(1)}, {16'h0, drum_out});
		setc(32'h39);
		scans(10);
		rc(`DSS_CSTEP_OFS, 32'h2, "no event");
		want <= 16'h0020;
		wait_done();
		rc(`DSS_CSTEP_OFS, 32'h3, "done step");
		@(negedge aclk);
		chk("done out", {16'h0, pat(2)}, {16'h0, drum_out});
		chk("flag", 32'h1, {31'h0, completion_flag});
		want <= 16'h0000;
		jog();
		rc(`DSS_CSTEP_OFS, 32'h3, "jog ignored");
		rc(`DSS_STATUS_OFS, 32'h3, "still done");
		wr(`DSS_PRESET_OFS, 32'h11);
		rc(`DSS_PSTEP_OFS, 32'h1, "bad preset");
		wr(`DSS_PRESET_OFS, 32'h2);
		setc(32'h3D);
		scans(10);
		rc(`DSS_CSTEP_OFS, 32'h2, "reset step");
		rc(`DSS_COUNT_OFS, 32'h0, "reset count");
		rc(`DSS_STATUS_OFS, 32'h0, "reset status");
		@(negedge aclk);
		chk("flag clear", 32'h0, {31'h0, completion_flag});
		setc(32'h38);
		jog();
		setc(32'h30);
		@(negedge aclk);
		chk("off out", 32'h0, {16'h0, drum_out});
		setc(32'h38);
		rc(`DSS_CSTEP_OFS, 32'h3, "retained");
		rc(`DSS_PSTEP_OFS, 32'h2, "preset kept");
		setc(32'h20);
		setc(32'h28);
		rc(`DSS_CSTEP_OFS, 32'h2, "reinit step");
		rc(`DSS_COUNT_OFS, 32'h0, "reinit count");
		rc(`DSS_TIMER_OFS, 32'h0, "reinit timer");
		jog();
		jog();
		rc(`DSS_STATUS_OFS, 32'h3, "jog done");
		rc(`DSS_CSTEP_OFS, 32'h3, "jog last");
		setc(32'h20);
		setc(32'h28);
		rc(`DSS_STATUS_OFS, 32'h0, "entry exit");
		rc(`DSS_CSTEP_OFS, 32'h2, "entry step");
		setc(32'h08);
		jog();
		rc(`DSS_CSTEP_OFS, 32'h2, "timed no jog");
		// timebase 3: step 1 lasts 15 hundredths, step 2 lasts 48
		wr(`DSS_TIMEBASE_OFS, 32'h3);
		rc(`DSS_TIMEBASE_OFS, 32'h3, "timebase");
		wr(8'h40, 32'h5);
		wr(8'h44, 32'h10);
		setc(32'h00);
		wr(`DSS_PRESET_OFS, 32'h1);
		setc(32'h08);
		setc(32'h09);
		// about 7 cycles after run is set: too few hundredths for step 1 to end at any timebase
		rc(`DSS_CSTEP_OFS, 32'h1, "timebase step");
		scans(25);
		rc(`DSS_CSTEP_OFS, 32'h2, "timebase next");
		wrap_up();
	end
endmodule
`default_nettype wire
